// >>> core/gpio_slice_pkg.sv
package gpio_slice_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_FEAT = 5;

	// feature index into the offset tables
	localparam int FEAT_CNT = 0;
	localparam int FEAT_AUX = 1;
	localparam int FEAT_MAP = 2;
	localparam int FEAT_RISE = 3;
	localparam int FEAT_FALL = 4;

	// entry k belongs to feature index k
	localparam logic [NUM_FEAT-1:0][ADDR_W-1:0] LOW_OFF = {8'h44, 8'h40, 8'h38, 8'h34, 8'h2c};
	localparam logic [NUM_FEAT-1:0][ADDR_W-1:0] HIGH_OFF = {8'hc4, 8'hc0, 8'hb8, 8'hb4, 8'hac};

	localparam logic [ADDR_W-1:0] LOW_RISE_STS_OFF = 8'h48;
	localparam logic [ADDR_W-1:0] HIGH_RISE_STS_OFF = 8'hc8;
	localparam logic [ADDR_W-1:0] LOW_FALL_STS_OFF = 8'h4c;
	localparam logic [ADDR_W-1:0] HIGH_FALL_STS_OFF = 8'hcc;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 8'he0;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'he4;

	localparam logic [DATA_W-1:0] FEATURE_RESET = 32'hffff0000;
	localparam logic [DATA_W-1:0] HIGH_AUX_RESET = 32'hefff1000;
	localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 32'h00000000;

	// high bank has no pins 23, 29, 30, 31
	localparam logic [15:0] LOW_VALID = 16'hffff;
	localparam logic [15:0] HIGH_VALID = 16'h1f7f;
	localparam logic [31:0] PIN_VALID = {HIGH_VALID, LOW_VALID};

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [31:0] fall;
		logic [31:0] rise;
		logic [31:0] map;
		logic [31:0] aux;
		logic [31:0] cnt;
	} pin_features_t;

	// low half sets, high half clears, clear wins, zeros keep
	function automatic logic [15:0] atomic_update(input logic [15:0] cur, input logic [31:0] w,
		input logic [15:0] vm);
		atomic_update = ((cur | w[15:0]) & ~w[31:16]) & vm;
	endfunction

	// absent pins read one in the clear half and zero in the set half, as every reset value shows
	function automatic logic [31:0] atomic_read(input logic [15:0] cur, input logic [15:0] vm);
		atomic_read = {~(cur & vm), cur & vm};
	endfunction

endpackage

// >>> core/gpio_input_slice.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - conditioned pin input reaches each internal destination only when its select is set: aux-one select or event count enable
// - aux-one select high picks auxiliary input one; low leaves it unselected
// - map enable high makes the pin eligible for interrupt and power event mapping
// - map enable only gates eligibility; destination choice lies in mapping logic elsewhere
// - rising edge detector runs only while its enable bit is high
// - falling edge detector runs only while its enable bit is high
// - each function has a low bank register (pins 0-15) and high bank (16-31)
// - high bank aux-one select resets with pin 28 selected
// - all other feature registers reset with every feature disabled
// - feature registers use two bits per pin, one in each half-word
// - event count enable high routes the pin into the event counter function
// - detected edges are held in status bits; read shows them, writing one clears
module gpio_input_slice (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] pin_in,
	input wire logic [gpio_slice_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gpio_slice_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] aux_one_out,
	output logic [31:0] counter_input_out,
	output logic [31:0] counter_enable_out,
	output logic [31:0] map_event_out,
	output logic irq
);

	gpio_slice_pkg::pin_features_t feat;
	logic [31:0] feat_arr [gpio_slice_pkg::NUM_FEAT];
	logic [31:0] pin_meta;
	logic [31:0] pin_sync;
	logic [31:0] pin_prev;
	logic [31:0] rise_hit;
	logic [31:0] fall_hit;
	logic [31:0] rise_sts;
	logic [31:0] fall_sts;
	logic [31:0] irq_status;
	logic [31:0] irq_mask;
	logic [31:0] rise_clr;
	logic [31:0] fall_clr;
	logic [31:0] irq_set;
	logic [31:0] irq_clr;
	logic [gpio_slice_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] strobe_mask;
	logic do_write;
	logic do_read;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_value;

	assign feat.cnt = feat_arr[gpio_slice_pkg::FEAT_CNT];
	assign feat.aux = feat_arr[gpio_slice_pkg::FEAT_AUX];
	assign feat.map = feat_arr[gpio_slice_pkg::FEAT_MAP];
	assign feat.rise = feat_arr[gpio_slice_pkg::FEAT_RISE];
	assign feat.fall = feat_arr[gpio_slice_pkg::FEAT_FALL];

	// pins are asynchronous; nothing reads pin_meta except pin_sync
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta <= 32'h00000000;
			pin_sync <= 32'h00000000;
			pin_prev <= 32'h00000000;
		end
		else if (ce)
		begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign rise_hit = pin_sync & ~pin_prev & feat.rise & gpio_slice_pkg::PIN_VALID;
	assign fall_hit = ~pin_sync & pin_prev & feat.fall & gpio_slice_pkg::PIN_VALID;

	// write channel: address and data taken in either order, response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gpio_slice_pkg::RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data <= s_axi_wdata & strobe_mask;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? gpio_slice_pkg::RESP_OKAY : gpio_slice_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// a masked byte lane writes zeros, which leave atomic bits unchanged
	assign strobe_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_comb
	begin
		wr_hit = (wr_addr == gpio_slice_pkg::LOW_RISE_STS_OFF)
			|| (wr_addr == gpio_slice_pkg::HIGH_RISE_STS_OFF)
			|| (wr_addr == gpio_slice_pkg::LOW_FALL_STS_OFF)
			|| (wr_addr == gpio_slice_pkg::HIGH_FALL_STS_OFF)
			|| (wr_addr == gpio_slice_pkg::IRQ_STATUS_OFF)
			|| (wr_addr == gpio_slice_pkg::IRQ_MASK_OFF);
		for (int k = 0; k < gpio_slice_pkg::NUM_FEAT; k++)
		begin
			if (wr_addr == gpio_slice_pkg::LOW_OFF[k] || wr_addr == gpio_slice_pkg::HIGH_OFF[k])
			begin
				wr_hit = 1'b1;
			end
		end
	end

	// one low and one high register per function, each with set and clear halves
	genvar f;
	generate
		for (f = 0; f < gpio_slice_pkg::NUM_FEAT; f++)
		begin : g_feat
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					if (f == gpio_slice_pkg::FEAT_AUX)
					begin
						feat_arr[f] <= {gpio_slice_pkg::HIGH_AUX_RESET[15:0],
							gpio_slice_pkg::FEATURE_RESET[15:0]};
					end
					else
					begin
						feat_arr[f] <= {gpio_slice_pkg::FEATURE_RESET[15:0],
							gpio_slice_pkg::FEATURE_RESET[15:0]};
					end
				end
				else if (ce && do_write)
				begin
					if (wr_addr == gpio_slice_pkg::LOW_OFF[f])
					begin
						feat_arr[f][15:0] <= gpio_slice_pkg::atomic_update(feat_arr[f][15:0],
							wr_data, gpio_slice_pkg::LOW_VALID);
					end
					if (wr_addr == gpio_slice_pkg::HIGH_OFF[f])
					begin
						feat_arr[f][31:16] <= gpio_slice_pkg::atomic_update(feat_arr[f][31:16],
							wr_data, gpio_slice_pkg::HIGH_VALID);
					end
				end
			end
		end
	endgenerate

	// a one in either half of a status write clears that pin's recorded edge
	always_comb
	begin
		rise_clr = 32'h00000000;
		fall_clr = 32'h00000000;
		if (do_write && wr_addr == gpio_slice_pkg::LOW_RISE_STS_OFF)
		begin
			rise_clr[15:0] = wr_data[15:0] | wr_data[31:16];
		end
		if (do_write && wr_addr == gpio_slice_pkg::HIGH_RISE_STS_OFF)
		begin
			rise_clr[31:16] = wr_data[15:0] | wr_data[31:16];
		end
		if (do_write && wr_addr == gpio_slice_pkg::LOW_FALL_STS_OFF)
		begin
			fall_clr[15:0] = wr_data[15:0] | wr_data[31:16];
		end
		if (do_write && wr_addr == gpio_slice_pkg::HIGH_FALL_STS_OFF)
		begin
			fall_clr[31:16] = wr_data[15:0] | wr_data[31:16];
		end
	end

	// a new edge in the clearing cycle survives: set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rise_sts <= 32'h00000000;
			fall_sts <= 32'h00000000;
		end
		else if (ce)
		begin
			rise_sts <= (rise_sts & ~rise_clr) | rise_hit;
			fall_sts <= (fall_sts & ~fall_clr) | fall_hit;
		end
	end

	// only pins cleared for mapping raise events; routing to a line happens elsewhere
	assign irq_set = (rise_hit | fall_hit) & feat.map;
	assign irq_clr = (do_read && s_axi_araddr == gpio_slice_pkg::IRQ_STATUS_OFF) ?
		32'hffffffff : 32'h00000000;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status <= 32'h00000000;
		end
		else if (ce)
		begin
			// read clears all, but an event in the same cycle survives
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_mask <= gpio_slice_pkg::IRQ_MASK_RESET;
		end
		else if (ce && do_write && wr_addr == gpio_slice_pkg::IRQ_MASK_OFF)
		begin
			irq_mask <= wr_data & gpio_slice_pkg::PIN_VALID;
		end
	end

	// read channel: one read outstanding, data one cycle after the address
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_comb
	begin
		rd_value = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			gpio_slice_pkg::LOW_RISE_STS_OFF:
				rd_value = gpio_slice_pkg::atomic_read(rise_sts[15:0], gpio_slice_pkg::LOW_VALID);
			gpio_slice_pkg::HIGH_RISE_STS_OFF:
				rd_value = gpio_slice_pkg::atomic_read(rise_sts[31:16], gpio_slice_pkg::HIGH_VALID);
			gpio_slice_pkg::LOW_FALL_STS_OFF:
				rd_value = gpio_slice_pkg::atomic_read(fall_sts[15:0], gpio_slice_pkg::LOW_VALID);
			gpio_slice_pkg::HIGH_FALL_STS_OFF:
				rd_value = gpio_slice_pkg::atomic_read(fall_sts[31:16], gpio_slice_pkg::HIGH_VALID);
			gpio_slice_pkg::IRQ_STATUS_OFF:
				rd_value = irq_status;
			gpio_slice_pkg::IRQ_MASK_OFF:
				rd_value = irq_mask;
			default:
				rd_hit = 1'b0;
		endcase
		for (int k = 0; k < gpio_slice_pkg::NUM_FEAT; k++)
		begin
			if (s_axi_araddr == gpio_slice_pkg::LOW_OFF[k])
			begin
				rd_hit = 1'b1;
				rd_value = gpio_slice_pkg::atomic_read(feat_arr[k][15:0],
					gpio_slice_pkg::LOW_VALID);
			end
			if (s_axi_araddr == gpio_slice_pkg::HIGH_OFF[k])
			begin
				rd_hit = 1'b1;
				rd_value = gpio_slice_pkg::atomic_read(feat_arr[k][31:16],
					gpio_slice_pkg::HIGH_VALID);
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= gpio_slice_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (do_read)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_value;
				s_axi_rresp <= rd_hit ? gpio_slice_pkg::RESP_OKAY : gpio_slice_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// internal destinations see the synchronised level, never the raw pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aux_one_out <= 32'h00000000;
			counter_input_out <= 32'h00000000;
			counter_enable_out <= 32'h00000000;
		end
		else if (ce)
		begin
			aux_one_out <= pin_sync & feat.aux;
			counter_enable_out <= feat.cnt;
			// counter has no filter here; software keeps the filter enabled
			counter_input_out <= pin_sync & feat.cnt;
		end
	end

	// one pulse per enabled edge on a pin that may be mapped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			map_event_out <= 32'h00000000;
		end
		else if (ce)
		begin
			map_event_out <= irq_set;
		end
	end

	// irq follows the next status value, so an event in the clearing read is not hidden
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq <= 1'b0;
		end
		else if (ce)
		begin
			irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
		end
	end

endmodule // gpio_input_slice

`default_nettype wire

// >>> verif/gpio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
	input wire logic aclk,
	input wire logic [31:0] level_req,
	output logic [31:0] pin_in
);
	logic flip = 1'b0;
	always @(posedge aclk) flip <= ~flip;
	// absent balls float: a changing level catches logic that samples them
	assign pin_in = {{3{flip}}, level_req[28:24], flip, level_req[22:0]};
endmodule // gpio_pin_model
`default_nettype wire

// >>> verif/gpio_input_slice_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_input_slice_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [gpio_slice_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] aux_one_out,
	input wire logic [31:0] counter_input_out,
	input wire logic [31:0] counter_enable_out,
	input wire logic [31:0] map_event_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read response missing");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_unmapped_error: assert property (s_rd_taken ##0 (s_axi_araddr == 8'h00) |=>
		s_axi_rresp == gpio_slice_pkg::RESP_SLVERR) else $error("unmapped read not refused");
	a_absent_quiet: assert property (((aux_one_out | counter_input_out | map_event_out)
		& ~gpio_slice_pkg::PIN_VALID) == '0) else $error("absent pin active");
	a_count_gated: assert property ((counter_input_out
		& ~(counter_enable_out | $past(counter_enable_out))) == '0) else $error("counter ungated");
	a_reset_quiet: assert property ($rose(aresetn) |->
		counter_enable_out == '0 && map_event_out == '0) else $error("outputs busy after reset");
endmodule // gpio_input_slice_chk
bind gpio_input_slice gpio_input_slice_chk chk (.*);
`default_nettype wire

// >>> verif/gpio_input_slice_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_input_slice_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [31:0] level_req = '0, pin_in, s_axi_wdata = '0, s_axi_rdata, rdat, want;
	logic [31:0] aux_one_out, counter_input_out, counter_enable_out, map_event_out;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, i1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	int mismatches = 0, checked = 0, pulses = 0, base;
	always #5 aclk = ~aclk;
	always @(posedge aclk) if (map_event_out[1] === 1'b1) pulses++;
	gpio_pin_model pins (.aclk, .level_req, .pin_in);
	gpio_input_slice uut (.*);
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// six cycles covers the two sync flops, the detector and the status flop
	task automatic pin(input int p, input logic v);
		@(posedge aclk);
		level_req[p] <= v;
		repeat (6) @(posedge aclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int f = 0; f < gpio_slice_pkg::NUM_FEAT; f++)
		begin
			rd(gpio_slice_pkg::LOW_OFF[f]);
			check("low reset", gpio_slice_pkg::FEATURE_RESET, rdat);
			if (f == gpio_slice_pkg::FEAT_AUX) want = gpio_slice_pkg::HIGH_AUX_RESET;
			else want = gpio_slice_pkg::FEATURE_RESET;
			rd(gpio_slice_pkg::HIGH_OFF[f]);
			check("high reset", want, rdat);
			wr(gpio_slice_pkg::LOW_OFF[f], 32'h000000ff);
			wr(gpio_slice_pkg::LOW_OFF[f], 32'h00010003);
			wr(gpio_slice_pkg::LOW_OFF[f], 32'h00000000);
			rd(gpio_slice_pkg::LOW_OFF[f]);
			check("low atomic", 32'hff0100fe, rdat);
			wr(gpio_slice_pkg::HIGH_OFF[f], 32'h0000ffff);
			rd(gpio_slice_pkg::HIGH_OFF[f]);
			check("high absent", 32'he0801f7f, rdat);
		end
		wr(8'h00, 32'h0000ffff);
		check("unmapped write", {30'h0, gpio_slice_pkg::RESP_SLVERR}, {30'h0, resp});
		rd(8'h00);
		check("unmapped read", {30'h0, gpio_slice_pkg::RESP_SLVERR}, {30'h0, resp});
		level_req <= '1;
		repeat (6) @(posedge aclk);
		check("count enable", 32'h1f7f00fe, counter_enable_out);
		check("count input", 32'h1f7f00fe, counter_input_out);
		check("aux input", 32'h1f7f00fe, aux_one_out);
		wr(gpio_slice_pkg::LOW_OFF[gpio_slice_pkg::FEAT_AUX], 32'h00020000);
		repeat (4) @(posedge aclk);
		check("aux cleared", 32'h1f7f00fc, aux_one_out);
		wr(gpio_slice_pkg::LOW_OFF[gpio_slice_pkg::FEAT_FALL], 32'h00020000);
		base = pulses;
		pin(1, 1'b0);
		check("fall off", base, pulses);
		pin(1, 1'b1);
		check("rise on", base + 1, pulses);
		wr(gpio_slice_pkg::LOW_OFF[gpio_slice_pkg::FEAT_MAP], 32'h00020000);
		pin(1, 1'b0);
		pin(1, 1'b1);
		check("map off", base + 1, pulses);
		wr(gpio_slice_pkg::IRQ_MASK_OFF, 32'h00000000);
		rd(gpio_slice_pkg::IRQ_STATUS_OFF);
		pin(2, 1'b0);
		i1 = irq;
		rd(gpio_slice_pkg::IRQ_STATUS_OFF);
		check("irq status", 32'h00000004, rdat);
		repeat (2) @(posedge aclk);
		check("irq cleared", 32'h0, {31'h0, irq});
		wr(gpio_slice_pkg::IRQ_MASK_OFF, 32'hffffffff);
		rd(gpio_slice_pkg::IRQ_MASK_OFF);
		check("mask", gpio_slice_pkg::PIN_VALID, rdat);
		pin(2, 1'b1);
		check("mask effect", 32'h1, {31'h0, i1 ^ irq});
		rd(gpio_slice_pkg::IRQ_STATUS_OFF);
		check("irq status set", 32'h00000004, rdat);
		repeat (2) @(posedge aclk);
		check("irq read clear", 32'h0, {31'h0, irq});
		rd(gpio_slice_pkg::LOW_FALL_STS_OFF);
		check("fall status", 32'hfffb0004, rdat);
		wr(gpio_slice_pkg::LOW_FALL_STS_OFF, 32'h00000004);
		rd(gpio_slice_pkg::LOW_FALL_STS_OFF);
		check("fall cleared", 32'hffff0000, rdat);
		// ce low freezes the synchronisers, so this pin change must stay unseen
		ce <= 1'b0;
		pin(3, 1'b0);
		check("frozen", 32'h1f7f00fc, aux_one_out);
		ce <= 1'b1;
		conclude();
	end
endmodule // gpio_input_slice_tb_top
`default_nettype wire
